// File: dmc_pattern_gen.sv
/*
 * constants for the mode and calibration control block, and the calibration
 * pattern generator that serves reads while pattern mode is on.
 * assumes: one link clock, two data beats per clock on the modelled dq lane.
 */
`default_nettype none

package dmc_pkg;
    // ------------------------------------------------------------------
    // command decode: {row strobe, column strobe, write enable}, active low
    // ------------------------------------------------------------------
    localparam logic [2:0]  DMC_CMD_MRS        = 3'h0;
    localparam logic [2:0]  DMC_CMD_READ       = 3'h5;
    localparam logic [2:0]  DMC_CMD_WRITE      = 3'h4;
    localparam logic [2:0]  DMC_BA_MODE1       = 3'h1;
    localparam logic [2:0]  DMC_BA_MODE2       = 3'h2;
    localparam logic [2:0]  DMC_BA_MODE3       = 3'h3;
    // ------------------------------------------------------------------
    // mode register fields and read command bits (address bit positions)
    // ------------------------------------------------------------------
    localparam int          DMC_WL_BIT         = 7;
    localparam int          DMC_AUTO_SR_BIT    = 6;
    localparam int          DMC_SR_RANGE_BIT   = 7;
    localparam int          DMC_PAT_EN_BIT     = 2;
    localparam int          DMC_LOC_LSB        = 0;
    localparam int          DMC_NIBBLE_BIT     = 2;
    localparam int          DMC_BL8_BIT        = 12;
    // ------------------------------------------------------------------
    // timing in command clock cycles
    // ------------------------------------------------------------------
    localparam int          DMC_TMOD_CK        = 12;
    localparam int          DMC_READ_LAT       = 5;
    // ------------------------------------------------------------------
    // pattern data, burst bit 0 in the lsb
    // ------------------------------------------------------------------
    localparam logic [7:0]  DMC_CAL_PATTERN    = 8'haa;
    localparam logic [7:0]  DMC_RFU_FILL       = 8'h00;
    // ------------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  DMC_OFF_CTRL       = 8'h00;
    localparam logic [7:0]  DMC_OFF_STATUS     = 8'h04;
    localparam logic [0:0]  DMC_CTRL_RESET     = 1'h1;
    localparam int          DMC_ST_WL          = 0;
    localparam int          DMC_ST_UNDEF       = 1;
    localparam int          DMC_ST_PAT_EN      = 2;
    localparam int          DMC_ST_LOC_LSB     = 3;
    localparam int          DMC_ST_AUTO        = 5;
    localparam int          DMC_ST_RANGE       = 6;
    localparam int          DMC_ST_ILLEGAL     = 7;
    localparam int          DMC_ST_W           = 8;

    typedef enum logic [1:0] {
        DMC_WL_OFF  = 2'h0,
        DMC_WL_ON   = 2'h1,
        DMC_WL_EXIT = 2'h3
    } dmc_wl_state_type;

    function automatic logic dmc_mr_hit(input logic mrs, input logic [2:0] ba,
                                        input logic [2:0] which);
        return mrs && (ba == which);
    endfunction
endpackage

module dmc_pattern_gen
    import dmc_pkg::*;
#(
    parameter int RD_LAT = DMC_READ_LAT
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       nibble_hi,
    input  wire logic       chop,
    input  wire logic       loc_cal,
    input  wire logic       hold_drive,
    output logic [1:0]      dq_q,
    output logic            oe_q
);
    // the pipe is one short of the latency: the load edge puts out beat 0
    localparam int DEPTH = RD_LAT - 1;

    logic [DEPTH-1:0][3:0]  pipe_q;
    logic [7:0]             sh_q;
    logic [1:0]             cnt_q;

    wire [3:0] top_entry   = pipe_q[DEPTH-1];
    wire       load        = top_entry[3];
    wire [7:0] src_word    = top_entry[0] ? DMC_CAL_PATTERN : DMC_RFU_FILL;
    wire [7:0] burst_word  = top_entry[2] ? {4'h0, src_word[7:4]} : src_word;
    wire [1:0] beats_after = top_entry[1] ? 2'h1 : 2'h3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= {pipe_q[DEPTH-2:0], {start, nibble_hi, chop, loc_cal}};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_q  <= 2'h0;
            sh_q  <= 8'h00;
            cnt_q <= 2'h0;
            oe_q  <= 1'b0;
        end else if (load) begin
            dq_q  <= burst_word[1:0];
            sh_q  <= {2'h0, burst_word[7:2]};
            cnt_q <= beats_after;
            oe_q  <= 1'b1;
        end else if (cnt_q != 2'h0) begin
            dq_q  <= sh_q[1:0];
            sh_q  <= {2'h0, sh_q[7:2]};
            cnt_q <= cnt_q - 2'h1;
            oe_q  <= 1'b1;
        end else begin
            dq_q  <= 2'h0;
            oe_q  <= hold_drive;
        end
    end
endmodule

`default_nettype wire

// File: dmc_mode_ctrl.sv
/*
 * mode register driven feature control of a ddr memory device: write
 * leveling exit, self-refresh temperature options, calibration pattern mode.
 * assumes: an apb master on pclk, a memory controller driving commands and
 * odt on the link clock; the link clock may run unrelated to pclk.
 */
`default_nettype none

// Operation
// - data pins undefined until tmod after exit
// - auto bit set, range clear: device self-manages
// - range bit picks normal or extended rate
// - pattern mode redirects reads per location
// - pattern off: array access, location ignored
// - leveling flag follows first register bit
// - location zero returns alternating zero one
module dmc_mode_ctrl
    import dmc_pkg::*;
#(
    parameter int TMOD_CYCLES = DMC_TMOD_CK,
    parameter int RD_LAT      = DMC_READ_LAT,
    parameter bit HAS_AUTO_SR = 1'b1,
    parameter bit HAS_EXT     = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  ba,
    input  wire logic [15:0] addr,
    input  wire logic        odt,
    output logic [1:0]       dq_out,
    output logic             dq_oe,
    output logic             dq_undefined,
    output logic             wl_active,
    output logic             rtt_strobe_on,
    output logic             rtt_data_on,
    output logic             array_rd,
    output logic             array_wr,
    output logic             sr_auto,
    output logic             sr_extended,
    output logic             sr_illegal
);
    // ------------------------------------------------------------------
    // link reset: asserted at once, released on the link clock
    // ------------------------------------------------------------------
    logic [1:0] lrst_q;
    wire        lrst_n = lrst_q[1];

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // apb slave, one wait state on every access
    // ------------------------------------------------------------------
    logic                  ctrl_q;
    logic [DMC_ST_W-1:0]   status_q;
    logic [31:0]           prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;

    wire apb_access = psel && penable;
    wire apb_first  = apb_access && !pready_q;
    wire apb_done   = apb_access && pready_q;
    wire hit_ctrl   = (paddr == DMC_OFF_CTRL);
    wire hit_status = (paddr == DMC_OFF_STATUS);
    wire [31:0] rd_mux = hit_ctrl   ? {31'h0, ctrl_q} :
                         hit_status ? {{(32-DMC_ST_W){1'b0}}, status_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= apb_first;
            pslverr_q <= apb_first && !(hit_ctrl || hit_status);
            if (apb_first && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // writes land only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= DMC_CTRL_RESET;
        end else if (apb_done && pwrite && hit_ctrl) begin
            ctrl_q <= pwdata[0];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // command accept enable into the link domain
    // ------------------------------------------------------------------
    logic en_meta_q;
    logic en_sync_q;

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
        end else begin
            en_meta_q <= ctrl_q;
            en_sync_q <= en_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    wire [2:0] cmd_code = {ras_n, cas_n, we_n};
    wire       cmd_sel  = en_sync_q && !cs_n;
    wire       mrs_cmd  = cmd_sel && (cmd_code == DMC_CMD_MRS);
    wire       rd_cmd   = cmd_sel && (cmd_code == DMC_CMD_READ);
    wire       wr_cmd   = cmd_sel && (cmd_code == DMC_CMD_WRITE);
    wire       mode1_cmd = dmc_mr_hit(mrs_cmd, ba, DMC_BA_MODE1);
    wire       mode2_cmd = dmc_mr_hit(mrs_cmd, ba, DMC_BA_MODE2);
    wire       mode3_cmd = dmc_mr_hit(mrs_cmd, ba, DMC_BA_MODE3);

    // ------------------------------------------------------------------
    // mode flags
    // ------------------------------------------------------------------
    logic       pat_en_q;
    logic [1:0] loc_q;
    logic       auto_sr_q;
    logic       sr_range_q;
    logic       sr_auto_q;
    logic       sr_ext_q;
    logic       sr_ill_q;

    // an optional feature the part lacks reads back as off
    wire auto_bit  = addr[DMC_AUTO_SR_BIT] && HAS_AUTO_SR;
    wire range_bit = addr[DMC_SR_RANGE_BIT] && HAS_EXT;

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            pat_en_q <= 1'b0;
            loc_q    <= 2'h0;
        end else if (mode3_cmd) begin
            pat_en_q <= addr[DMC_PAT_EN_BIT];
            loc_q    <= addr[DMC_LOC_LSB +: 2];
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            auto_sr_q  <= 1'b0;
            sr_range_q <= 1'b0;
            sr_auto_q  <= 1'b0;
            sr_ext_q   <= 1'b0;
            sr_ill_q   <= 1'b0;
        end else if (mode2_cmd) begin
            auto_sr_q  <= auto_bit;
            sr_range_q <= range_bit;
            sr_auto_q  <= auto_bit && !range_bit;
            sr_ext_q   <= !auto_bit && range_bit;
            sr_ill_q   <= auto_bit && range_bit;
        end
    end

    // ------------------------------------------------------------------
    // write leveling: the exit holds dq undefined for tmod cycles
    // ------------------------------------------------------------------
    dmc_wl_state_type wl_state_q;
    dmc_wl_state_type wl_state_d;
    logic [7:0]       exit_cnt_q;
    logic             undef_q;
    logic             wl_q;

    wire wl_set       = mode1_cmd && addr[DMC_WL_BIT];
    wire wl_exit_cmd  = mode1_cmd && !addr[DMC_WL_BIT] && (wl_state_q == DMC_WL_ON);
    wire exit_expired = (wl_state_q == DMC_WL_EXIT) && (exit_cnt_q == 8'h00);

    always_comb begin
        wl_state_d = wl_state_q;
        case (wl_state_q)
            DMC_WL_OFF:  if (wl_set) wl_state_d = DMC_WL_ON;
            DMC_WL_ON:   if (wl_exit_cmd) wl_state_d = DMC_WL_EXIT;
            DMC_WL_EXIT: begin
                if (wl_set) begin
                    wl_state_d = DMC_WL_ON;
                end else if (exit_expired) begin
                    wl_state_d = DMC_WL_OFF;
                end
            end
            default:     wl_state_d = DMC_WL_OFF;
        endcase
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            wl_state_q <= DMC_WL_OFF;
            exit_cnt_q <= 8'h00;
            undef_q    <= 1'b0;
            wl_q       <= 1'b0;
        end else begin
            wl_state_q <= wl_state_d;
            exit_cnt_q <= wl_exit_cmd ? 8'(TMOD_CYCLES - 1) :
                          (exit_cnt_q != 8'h00) ? exit_cnt_q - 8'h01 : 8'h00;
            undef_q    <= (wl_state_d != DMC_WL_OFF);
            wl_q       <= (wl_state_d == DMC_WL_ON);
        end
    end

    // ------------------------------------------------------------------
    // termination, array strobes
    // ------------------------------------------------------------------
    logic rtt_strobe_q;
    logic rtt_data_q;
    logic array_rd_q;
    logic array_wr_q;

    // while leveling only the strobe pair terminates; data stays open
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rtt_strobe_q <= 1'b0;
            rtt_data_q   <= 1'b0;
            array_rd_q   <= 1'b0;
            array_wr_q   <= 1'b0;
        end else begin
            rtt_strobe_q <= odt;
            rtt_data_q   <= odt && !wl_q;
            array_rd_q   <= rd_cmd && !pat_en_q;
            array_wr_q   <= wr_cmd && !pat_en_q;
        end
    end

    // ------------------------------------------------------------------
    // pattern readout
    // ------------------------------------------------------------------
    wire pat_rd = rd_cmd && pat_en_q;
    wire loc_cal = (loc_q == 2'h0);

    dmc_pattern_gen #(
        .RD_LAT     (RD_LAT)
    ) u_pattern (
        .clk        (link_clk),
        .rst_n      (lrst_n),
        .start      (pat_rd),
        .nibble_hi  (addr[DMC_NIBBLE_BIT]),
        .chop       (!addr[DMC_BL8_BIT]),
        .loc_cal    (loc_cal),
        .hold_drive (wl_state_d != DMC_WL_OFF),
        .dq_q       (dq_out),
        .oe_q       (dq_oe)
    );

    // ------------------------------------------------------------------
    // status snapshot to pclk by request and acknowledge toggles
    // ------------------------------------------------------------------
    logic [DMC_ST_W-1:0] hold_q;
    logic                req_q;
    logic                ack_meta_q;
    logic                ack_sync_q;
    logic                req_meta_q;
    logic                req_sync_q;
    logic                ack_q;

    wire [DMC_ST_W-1:0] live_status = {sr_ill_q, sr_range_q, auto_sr_q, loc_q,
                                       pat_en_q, undef_q, wl_q};
    // the snapshot is frozen until pclk has taken it, so its bits never skew
    wire link_idle = (req_q == ack_sync_q);

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            hold_q     <= '0;
            req_q      <= 1'b0;
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= ack_q;
            ack_sync_q <= ack_meta_q;
            if (link_idle && (live_status != hold_q)) begin
                hold_q <= live_status;
                req_q  <= !req_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
            ack_q      <= 1'b0;
            status_q   <= '0;
        end else begin
            req_meta_q <= req_q;
            req_sync_q <= req_meta_q;
            if (req_sync_q != ack_q) begin
                status_q <= hold_q;
                ack_q    <= req_sync_q;
            end
        end
    end

    assign dq_undefined  = undef_q;
    assign wl_active     = wl_q;
    assign rtt_strobe_on = rtt_strobe_q;
    assign rtt_data_on   = rtt_data_q;
    assign array_rd      = array_rd_q;
    assign array_wr      = array_wr_q;
    assign sr_auto       = sr_auto_q;
    assign sr_extended   = sr_ext_q;
    assign sr_illegal    = sr_ill_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_cal_burst;
        (dq_oe && dq_out == 2'h2) [*2];
    endsequence

    sequence s_exit_hold;
        dq_undefined ##(TMOD_CYCLES - 1) dq_undefined;
    endsequence

    chk_undef_hold: assert property (@(posedge link_clk) disable iff (!lrst_n)
        wl_exit_cmd ##1 !mode1_cmd [*1] |-> s_exit_hold)
        else $error("dq released before tmod after leveling exit");

    chk_undef_release: assert property (@(posedge link_clk) disable iff (!lrst_n)
        exit_expired && !mode1_cmd |=> !dq_undefined && !wl_active)
        else $error("dq still undefined after tmod");

    chk_wl_follow: assert property (@(posedge link_clk) disable iff (!lrst_n)
        mode1_cmd |=> wl_active == $past(addr[DMC_WL_BIT]))
        else $error("leveling flag does not follow mode write");

    chk_flags_hold: assert property (@(posedge link_clk) disable iff (!lrst_n)
        !mode3_cmd && !mode2_cmd |=> $stable(pat_en_q) && $stable(loc_q) && $stable(sr_range_q))
        else $error("mode flag changed without mode write");

    chk_auto_sr: assert property (@(posedge link_clk) disable iff (!lrst_n)
        mode2_cmd && addr[DMC_AUTO_SR_BIT] && !addr[DMC_SR_RANGE_BIT] |=>
            sr_auto == HAS_AUTO_SR && !sr_extended && !sr_illegal)
        else $error("auto self-refresh not selected");

    chk_range_sel: assert property (@(posedge link_clk) disable iff (!lrst_n)
        mode2_cmd && !addr[DMC_AUTO_SR_BIT] |=>
            sr_extended == (HAS_EXT && $past(addr[DMC_SR_RANGE_BIT])) && !sr_auto)
        else $error("self-refresh range not selected by range bit");

    chk_rd_redirect: assert property (@(posedge link_clk) disable iff (!lrst_n)
        pat_rd |=> !array_rd ##(RD_LAT - 1) dq_oe)
        else $error("pattern read reached the array or no data");

    chk_cal_pattern: assert property (@(posedge link_clk) disable iff (!lrst_n)
        pat_rd && loc_cal |-> ##(RD_LAT) s_cal_burst)
        else $error("calibration pattern wrong");

    chk_normal_array: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (rd_cmd || wr_cmd) && !pat_en_q |=> array_rd || array_wr)
        else $error("normal access not sent to array");

    chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        apb_first |=> pready ##1 !pready)
        else $error("apb answer not one wait state");
endmodule

`default_nettype wire

// File: dmc_ctl_model.sv
/*
 * memory controller model: drives commands and termination on the link clock.
 * assumes: the bench calls its tasks one at a time; one-cycle commands.
 */
`default_nettype none
module dmc_ctl_model
    import dmc_pkg::*;
(
    input  wire logic        link_clk,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [2:0]       ba,
    output logic [15:0]      addr,
    output logic             odt
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // command driving
    // ------------------------------------------------------------------
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h0;
        addr = 16'h0000;
        odt = 1'b0;
    end
    task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
        @(posedge link_clk);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
        ba <= b;
        addr <= a;
        @(posedge link_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hf;
        // released lines flip so a stale address never passes for a live one
        ba <= ~b;
        addr <= ~a;
    endtask
    // strobes are never driven here; odt drops and stays low before exit
    task automatic set_odt(input logic v);
        @(posedge link_clk);
        odt <= v;
    endtask
    // tmod also covers tmrd; only reads follow a pattern enable
    task automatic settle();
        repeat (DMC_TMOD_CK) @(posedge link_clk);
    endtask
endmodule
`default_nettype wire

// File: dmc_mode_ctrl_tb_top.sv
/*
 * self-checking bench for the mode and calibration control block.
 * assumes: dmc_pkg, dmc_mode_ctrl and dmc_ctl_model are compiled first.
 */
`default_nettype none
module dmc_mode_ctrl_tb_top
    import dmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0, link_clk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    wire logic   cs_n, ras_n, cas_n, we_n, odt;
    wire logic [2:0]  ba;
    wire logic [15:0] addr;
    logic [1:0]  dq_out;
    logic        dq_oe, dq_undefined, wl_active, rtt_strobe_on, rtt_data_on;
    logic        array_rd, array_wr, sr_auto, sr_extended, sr_illegal;
    int          errors = 0, n_checks = 0;

    always #25 pclk = ~pclk;
    // link clock offset so its edges never line up with pclk
    initial begin
        #7;
        forever #80 link_clk = ~link_clk;
    end
    dmc_mode_ctrl uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .link_clk, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt, .dq_out,
        .dq_oe, .dq_undefined, .wl_active, .rtt_strobe_on, .rtt_data_on, .array_rd, .array_wr,
        .sr_auto, .sr_extended, .sr_illegal);
    dmc_ctl_model ctl (.link_clk, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt);
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic lk(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask
    task automatic burst(input logic [15:0] a, input int n, input logic [2:0] e);
        ctl.cmd(DMC_CMD_READ, 3'h5, a);
        #1;
        chk("array rd", 32'h0, array_rd);
        lk(3);
        chk("early oe", 32'h0, dq_oe);
        repeat (n) begin
            lk(1);
            chk("beat", e, {dq_oe, dq_out});
        end
        lk(1);
        chk("oe end", 32'h0, dq_oe);
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DMC_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        apb(1'b0, DMC_OFF_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b1, 8'h08, 32'h1);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, DMC_OFF_STATUS, 32'hff);
        chk("status wr", 32'h0, {31'h0, err});
        lk(8);
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE1, 16'h0080);
        #1;
        chk("wl on", 32'h3, {wl_active, dq_undefined});
        ctl.set_odt(1'b1);
        lk(2);
        chk("rtt wl", 32'h2, {rtt_strobe_on, rtt_data_on});
        ctl.set_odt(1'b0);
        lk(2);
        chk("rtt off", 32'h0, rtt_strobe_on);
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE1, 16'h0000);
        #1;
        chk("wl off", 32'h0, wl_active);
        lk(11);
        chk("undef hold", 32'h1, dq_undefined);
        lk(1);
        chk("undef end", 32'h0, dq_undefined);
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE3, 16'h0004);
        ctl.settle();
        apb(1'b0, DMC_OFF_STATUS, 32'h0);
        chk("status pat", 32'h4, rd);
        burst(16'h1000, 4, 3'b110);
        burst(16'h0004, 2, 3'b110);
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE3, 16'h0005);
        ctl.settle();
        burst(16'h1000, 4, 3'b100);
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE3, 16'h0003);
        ctl.settle();
        ctl.cmd(DMC_CMD_READ, 3'h0, 16'h1000);
        #1;
        chk("array rd", 32'h1, array_rd);
        lk(5);
        chk("no pat oe", 32'h0, {array_rd, dq_oe});
        ctl.cmd(DMC_CMD_WRITE, 3'h0, 16'h0000);
        #1;
        chk("array wr", 32'h1, array_wr);
        // last pass writes the illegal pair on purpose
        for (int i = 0; i < 4; i++) begin
            ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE2, 16'(i << 6));
            ctl.settle();
            chk("sr", {i[0] & i[1], i[1] & ~i[0], i[0] & ~i[1]},
                {sr_illegal, sr_extended, sr_auto});
        end
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE3, 16'h0000);
        lk(2);
        chk("sr kept", 32'h4, {sr_illegal, sr_extended, sr_auto});
        apb(1'b1, DMC_OFF_CTRL, 32'h0);
        lk(8);
        ctl.cmd(DMC_CMD_MRS, DMC_BA_MODE1, 16'h0080);
        lk(1);
        chk("ignored", 32'h0, wl_active);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
